// [logic/wdt_status_top.sv]
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
module wdt_status_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic wdt_clear,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic window_open,
  output logic armed
);
  import wdt_status_pkg::*;

  typedef struct packed {
    wdt_cfg_t cfg;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic open;
    logic armed;
  } top_t;

  top_t s_r;
  top_t s_nxt;
  logic [17:0] ps;
  logic [4:0] win;
  logic open_c;

  // ----------------------------------------------------------------
  // Counter and window decode
  // ----------------------------------------------------------------
  wdt_counter #(.PW(PRESCALE_W)) u_cnt (
    .clk(clk),
    .nrst(nrst),
    .run(s_r.cfg.on),
    .clear(wdt_clear),
    .rate(s_r.cfg.rate),
    .prescale(ps),
    .win(win)
  );

  wdt_window_decode u_dec (
    .wsel(s_r.cfg.wsel),
    .win(win),
    .open(open_c)
  );

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Answers one cycle after setup; the status view is read-only, so writes
  // to it and to unmapped addresses flag pslverr instead of storing.
  logic acc;
  logic [31:0] rd;
  logic hit;

  always_comb
  begin
    s_nxt = s_r;
    acc = psel && !penable;
    rd = 32'h0;
    hit = 1'b1;
    unique case (paddr)
      ADDR_CONTROL_A: rd = 32'({s_r.cfg.rate, s_r.cfg.on});
      ADDR_CONTROL_B: rd = 32'(s_r.cfg.wsel);
      ADDR_PRESCALE_LOW: rd = 32'(ps[7:0]);
      ADDR_PRESCALE_HIGH: rd = 32'(ps[15:8]);
      ADDR_COUNT_STATUS:
        rd = 32'({win, s_r.armed, ps[17:16]});
      default: hit = 1'b0;
    endcase
    s_nxt.ready = acc;
    s_nxt.err = 1'b0;
    if (acc)
    begin
      s_nxt.rdata = pwrite ? 32'h0 : rd;
      s_nxt.err = !hit || (pwrite && paddr != ADDR_CONTROL_A
                  && paddr != ADDR_CONTROL_B);
      if (pwrite && paddr == ADDR_CONTROL_A)
      begin
        s_nxt.cfg.rate = pwdata[RATE_LSB +: RATE_W];
        s_nxt.cfg.on = pwdata[ON_BIT];
      end
      if (pwrite && paddr == ADDR_CONTROL_B)
        s_nxt.cfg.wsel = pwdata[WSEL_LSB +: WSEL_W];
    end
    s_nxt.armed = s_nxt.cfg.on;
    s_nxt.open = open_c;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_r <= '0;
      s_r.cfg.rate <= RATE_RESET;
      s_r.cfg.wsel <= WSEL_RESET;
    end
    else
      s_r <= s_nxt;
  end

  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.err;
  assign window_open = s_r.open;
  assign armed = s_r.armed;
endmodule // wdt_status_top

// [include/wdt_status_pkg.sv]
package wdt_status_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CONTROL_A = 12'h000;
  localparam logic [11:0] ADDR_CONTROL_B = 12'h004;
  localparam logic [11:0] ADDR_PRESCALE_LOW = 12'h008;
  localparam logic [11:0] ADDR_PRESCALE_HIGH = 12'h00C;
  localparam logic [11:0] ADDR_COUNT_STATUS = 12'h010;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int RATE_LSB = 1;
  localparam int RATE_W = 5;
  localparam int ON_BIT = 0;
  localparam int WSEL_LSB = 0;
  localparam int WSEL_W = 3;
  localparam int WIN_LSB = 3;
  localparam int ARMED_BIT = 2;
  localparam logic [4:0] RATE_RESET = 5'h0B;
  localparam logic [4:0] RATE_MAX = 5'h12;
  localparam logic [2:0] WSEL_RESET = 3'h7;
  localparam int PRESCALE_W = 18;
  localparam int WIN_W = 5;
  localparam int BASE_SHIFT = 5;
  localparam logic [2:0] WSEL_FULL_OPEN = 3'h7;
  localparam logic [4:0] WIN_STEP = 5'h04;

  typedef struct packed {
    logic [4:0] rate;
    logic on;
    logic [2:0] wsel;
  } wdt_cfg_t;

  typedef struct packed {
    logic [4:0] win;
    logic armed;
    logic [17:0] prescale;
    logic open;
    logic tick;
  } wdt_stat_t;

endpackage

// [logic/wdt_window_decode.sv]
`timescale 1ns/1ps
module wdt_window_decode (
  input wire logic [2:0] wsel,
  input wire logic [4:0] win,
  output logic open
);
  import wdt_status_pkg::*;

  // ----------------------------------------------------------------
  // Open boundary
  // ----------------------------------------------------------------
  // Boundary is four counts per select step below 111.
  function automatic logic [4:0] open_floor(input logic [2:0] s);
    open_floor = 5'(5'h1C - 5'(s) * WIN_STEP);
  endfunction

  always_comb
  begin
    if (wsel == WSEL_FULL_OPEN)
      open = 1'b1;
    else
      open = (win >= open_floor(wsel));
  end
endmodule // wdt_window_decode

// [logic/wdt_counter.sv]
`timescale 1ns/1ps
module wdt_counter #(
  parameter int PW = 18
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic clear,
  input wire logic [4:0] rate,
  output logic [PW-1:0] prescale,
  output logic [4:0] win
);
  import wdt_status_pkg::*;

  typedef struct packed {
    logic [PW-1:0] ps;
    logic [4:0] post;
    logic [4:0] win;
  } cnt_t;

  cnt_t q_r;
  cnt_t q_nxt;

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  // The timeout is 2^(rate+5) cycles for rate up to 18 (higher rates act as 0); the window value is its top five bits,
  // so it sweeps uniformly over one period. Rates past 18 bits use a
  // postscaler so the prescale counter stays 18 bits wide.
  function automatic logic [4:0] eff(input logic [4:0] r);
    eff = (r > RATE_MAX) ? 5'h00 : r;
  endfunction

  function automatic logic [23:0] period_mask(input logic [4:0] r);
    period_mask = ~(24'hFFFFFF << (r + 5'(BASE_SHIFT)));
  endfunction

  logic [4:0] sh;
  logic [23:0] full;

  always_comb
  begin
    q_nxt = q_r;
    sh = eff(rate);
    full = 24'({q_r.post, q_r.ps}) & period_mask(sh);
    if (clear || !run)
    begin
      q_nxt = '0;
    end
    else
    begin
      full = 24'(full + 24'h1);
      full = full & period_mask(sh);
      q_nxt.ps = full[PW-1:0];
      q_nxt.post = 5'(full >> PW);
      q_nxt.win = 5'(full >> sh);
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign prescale = q_r.ps;
  assign win = q_r.win;
endmodule // wdt_counter

// [dv/wdt_status_chk.sv]
`timescale 1ns/1ps
module wdt_status_chk
  import wdt_status_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic armed
);
  logic st;
  assign st = psel && !penable;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_rdy_next: assert property (st |=> pready) else $error("late ready");
  a_rdy_pulse: assert property (pready |=> !pready) else $error("long ready");
  a_rdy_access: assert property (pready |-> psel && penable)
    else $error("stray ready");
  a_status_ro: assert property (
    st && pwrite && paddr == ADDR_COUNT_STATUS |=> pslverr)
    else $error("status write taken");
  a_prescale_ro: assert property (
    st && pwrite && paddr[11:3] == 9'h001 |=> pslverr)
    else $error("prescale write taken");
  a_ctrl_ok: assert property (
    st && paddr == ADDR_CONTROL_B |=> !pslverr)
    else $error("control refused");
  a_armed_view: assert property (
    pready && !pwrite && paddr == ADDR_COUNT_STATUS
    |-> prdata[2] == armed && prdata[31:8] == 0)
    else $error("armed bit wrong");
  a_reset_quiet: assert property ($rose(nrst) |-> !pready && !armed)
    else $error("busy after reset");
endmodule // wdt_status_chk
bind wdt_status_top wdt_status_chk i_chk (.clk, .nrst, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .armed);

// [dv/windowed_watchdog_count_status_tb.sv]
`timescale 1ns/1ps
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin \
  failures++; $display("unexpected %0t mismatch", $time); end end
module windowed_watchdog_count_status_tb;
  import wdt_status_pkg::*;
  logic clk, nrst, psel, penable, pwrite, wdt_clear, exp_open;
  logic pready, pslverr, window_open, armed, last_open;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, last;
  logic [64:0] q[$];
  logic [64:0] e;
  int failures, total_checks, cyc;
  wdt_status_top i_dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .wdt_clear, .prdata, .pready, .pslverr, .window_open, .armed);
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (psel && penable && pready === 1'b1)
    begin
      e = q.pop_front();
      `CHK({pslverr, prdata & e[63:32]}, {e[64], e[31:0]})
    end
    if (cyc > 5000)
    begin
      failures++;
      give_verdict();
    end
  end
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d,
    logic [64:0] x);
    q.push_back(x);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    last = prdata;
    last_open = window_open;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] v);
    apb(0, a, $urandom, {1'b0, 32'hFFFF_FFFF, v});
  endtask
  task automatic bad(logic wr, logic [11:0] a);
    apb(wr, a, $urandom, {1'b1, 64'h0});
  endtask
  initial
  begin
    {psel, penable, pwrite, wdt_clear, nrst} = '0;
    paddr = '0;
    pwdata = '0;
    void'($urandom(77));
    repeat (8) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    rd(ADDR_CONTROL_A, 32'h16);
    rd(ADDR_CONTROL_B, 32'h07);
    rd(ADDR_COUNT_STATUS, 0);
    rd(ADDR_PRESCALE_LOW, 0);
    rd(ADDR_PRESCALE_HIGH, 0);
    bad(1, ADDR_COUNT_STATUS);
    bad(1, ADDR_PRESCALE_LOW);
    bad(1, ADDR_PRESCALE_HIGH);
    bad(0, 12'h014);
    rd(ADDR_COUNT_STATUS, 0);
    $display("test reset done");
    wdt_clear <= 1;
    apb(1, ADDR_CONTROL_A, 1, 0);
    `CHK(armed, 1'b1)
    rd(ADDR_COUNT_STATUS, 32'h04);
    rd(ADDR_PRESCALE_HIGH, 0);
    wdt_clear <= 0;
    $display("test clear done");
    // Stopping the count clears it, so the sweep lets it run at the
    // shortest rate; each status read pairs a window value with its flag.
    repeat (4)
    begin
      apb(1, ADDR_CONTROL_A, 1, 0);
      repeat ($urandom_range(31)) @(posedge clk);
      for (int s = 0; s < 8; s++)
      begin
        apb(1, ADDR_CONTROL_B, s, 0);
        apb(0, ADDR_COUNT_STATUS, 0, 0);
        exp_open = s == 7 || last[7:3] >= 28 - 4 * s;
        `CHK(last_open, exp_open)
      end
    end
    $display("test sweep done");
    apb(1, ADDR_CONTROL_A, 32'h3, 0);
    repeat (20) @(posedge clk);
    nrst <= 0;
    repeat (2) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    rd(ADDR_COUNT_STATUS, 0);
    rd(ADDR_CONTROL_A, 32'h16);
    `CHK(armed, 1'b0)
    $display("test rereset done");
    give_verdict();
  end
endmodule // windowed_watchdog_count_status_tb
